// ==== design/spf_pkg.sv ====
// Constants, types and register map of the setup panel and fault indicator
// Summary of operation
// - Dec shows group, inc shows device part
// - Both keys held four seconds: edit, flashing
// - In edit, keys lower or raise address
// - Twenty seconds idle in edit: save, reset
// - No fault: three steady dots, no number
// - Active fault shows its code flashing
// - Show only the top-priority (lowest-code) active fault
// - Fault codes one to sixteen, eleven unused
// - Codes 1,2,4,10,12,13,16 open output switch
// - Other faults displayed, output switch unchanged
// - Motor-blocked opens switch after five seconds
// - Setup keys forward parameter edits to network
// - Guider lock closed holds actuator position
package spf_pkg;

  localparam int CLK_MHZ = 250;
  localparam int MS_NS = 1000000;
  // One millisecond of sys_clk; above 4096 so the top takes it as parameter
  localparam int MS_CYCLES = MS_NS / 1000 * CLK_MHZ;

  localparam logic [14:0] EDIT_HOLD_MS = 15'h0fa0;   // 4000 ms
  localparam logic [14:0] SAVE_IDLE_MS = 15'h4e20;   // 20000 ms
  localparam logic [14:0] BLOCKED_MS = 15'h1388;     // 5000 ms
  localparam logic [14:0] FLASH_MS = 15'h01f4;       // 500 ms per phase

  localparam int NUM_FAULTS = 16;
  // Bit k stands for fault code k+1
  localparam logic [15:0] SIGNAL_MASK = 16'h9a0b;
  localparam int BLOCKED_BIT = 12;

  localparam logic [2:0] GROUP_RST = 3'h0;
  localparam logic [3:0] DEVICE_RST = 4'h5;
  localparam logic [3:0] DEVICE_MIN = 4'h1;
  localparam logic [3:0] DEVICE_MAX = 4'hf;
  localparam logic [2:0] GROUP_MAX = 3'h7;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam logic [7:0] REG_FAULT = 8'h10;
  localparam logic [7:0] REG_PANEL = 8'h14;

  localparam int IRQ_FAULT = 0;
  localparam int IRQ_SAVED = 1;
  localparam int IRQ_KEY = 2;
  localparam int IRQ_LOCK = 3;
  localparam int NUM_IRQ = 4;

  localparam int KEY_SETUP = 0;
  localparam int KEY_DEC = 1;
  localparam int KEY_INC = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_VIEW, ST_EDIT} spf_state_e;

endpackage

// ==== design/spf_tick_div.sv ====
// Millisecond enable divider
module spf_tick_div #(
  parameter int unsigned CYCLES = 250000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic msTick
);

  logic [31:0] cnt_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      msTick <= 1'b0;
    end else if (cnt_ff == 32'(CYCLES - 1)) begin
      cnt_ff <= 32'h0;
      msTick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      msTick <= 1'b0;
    end
  end

endmodule

// ==== design/spf_fault_prio.sv ====
// Priority selection of the displayed fault code
module spf_fault_prio (
  input wire logic [15:0] faults,
  output logic [4:0] code
);

  // Lowest code wins; zero means nothing active
  function automatic logic [4:0] lowest_code(input logic [15:0] f);
    logic [4:0] c;
    c = 5'h0;
    for (int i = spf_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
      if (f[i]) begin
        c = 5'(i + 1);
      end
    end
    return c;
  endfunction

  assign code = lowest_code(faults);

endmodule

// ==== design/spf_panel.sv ====
// Setup panel, address editor, fault display and fault output with APB
module spf_panel #(
  parameter int unsigned MS_CYCLES = spf_pkg::MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic keySetup,
  input wire logic keyDec,
  input wire logic keyInc,
  input wire logic [15:0] faultIn,
  input wire logic guiderLock,
  output logic [7:0] dispNumber,
  output logic dispNumOn,
  output logic [2:0] dispDots,
  output logic faultSwitch,
  output logic holdPosition,
  output logic [2:0] addrGroup,
  output logic [3:0] addrDevice,
  output logic nvSave,
  output logic swReset,
  output logic [2:0] paramKeyEvt
);

  typedef struct packed {
    spf_pkg::spf_state_e st;
    logic [2:0] keyPrev;
    logic [14:0] holdMs;
    logic [14:0] idleMs;
    logic [14:0] blkMs;
    logic [14:0] flashMs;
    logic flashOn;
    logic [2:0] group;
    logic [3:0] device;
    logic setupEn;
    logic [3:0] irqStat;
    logic [3:0] irqMask;
    logic anyPrev;
    logic lockPrev;
    logic saved;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] dispNumber;
    logic dispNumOn;
    logic [2:0] dispDots;
    logic faultSwitch;
    logic holdPos;
    logic nvSave;
    logic swReset;
    logic [2:0] paramKeyEvt;
  } spf_state_s;

  // Register selects; the unused code falls to the unmapped branch
  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_STATUS,
    SEL_MASK,
    SEL_ADDR,
    SEL_FAULT,
    SEL_PANEL,
    SEL_NONE
  } spf_sel_e;

  // Reads and writes share one decoder so they always agree on the map
  function automatic spf_sel_e reg_select(input logic [7:0] a);
    spf_sel_e s;
    unique case (a)
      spf_pkg::REG_CTRL: s = SEL_CTRL;
      spf_pkg::REG_STATUS: s = SEL_STATUS;
      spf_pkg::REG_MASK: s = SEL_MASK;
      spf_pkg::REG_ADDR: s = SEL_ADDR;
      spf_pkg::REG_FAULT: s = SEL_FAULT;
      spf_pkg::REG_PANEL: s = SEL_PANEL;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  localparam spf_state_s RST_STATE = '{
    st: spf_pkg::ST_IDLE,
    group: spf_pkg::GROUP_RST,
    device: spf_pkg::DEVICE_RST,
    faultSwitch: 1'b1,
    default: '0
  };

  spf_state_s cur_ff;
  spf_state_s nxt_cur;

  logic msTick;
  logic [4:0] shownCode;
  logic [2:0] keys;
  logic [2:0] keyRise;
  logic [15:0] signalFaults;
  logic blockedLong;
  logic setupAcc;
  logic wrAcc;
  logic [3:0] irqSet;
  logic [3:0] irqClr;
  spf_sel_e regSel;

  spf_tick_div #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .msTick(msTick)
  );

  spf_fault_prio u_prio (
    .faults(faultIn),
    .code(shownCode)
  );

  assign keys = {keyInc, keyDec, keySetup};
  assign keyRise = keys & ~cur_ff.keyPrev;
  assign setupAcc = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign regSel = reg_select(paddr);
  assign blockedLong = cur_ff.blkMs == spf_pkg::BLOCKED_MS;

  // Motor-blocked reaches the output only once it has lasted long enough
  always_comb begin
    signalFaults = faultIn & spf_pkg::SIGNAL_MASK;
    signalFaults[spf_pkg::BLOCKED_BIT] =
      faultIn[spf_pkg::BLOCKED_BIT] && blockedLong;
  end

  always_comb begin
    logic bothHeld;
    logic anyHeld;
    logic anyFault;
    logic [6:0] addr;
    bothHeld = keyDec && keyInc;
    anyHeld = |keys;
    anyFault = |faultIn;
    addr = {cur_ff.group, cur_ff.device};
    nxt_cur = cur_ff;
    irqSet = 4'h0;
    irqClr = 4'h0;
    nxt_cur.keyPrev = keys;
    nxt_cur.nvSave = 1'b0;
    nxt_cur.swReset = 1'b0;
    nxt_cur.paramKeyEvt = 3'h0;
    nxt_cur.pready = 1'b1;

    // Flash phase runs free so all flashing displays blink together
    if (msTick) begin
      if (cur_ff.flashMs == spf_pkg::FLASH_MS - 15'h1) begin
        nxt_cur.flashMs = 15'h0;
        nxt_cur.flashOn = !cur_ff.flashOn;
      end else begin
        nxt_cur.flashMs = cur_ff.flashMs + 15'h1;
      end
    end

    if (!faultIn[spf_pkg::BLOCKED_BIT]) begin
      nxt_cur.blkMs = 15'h0;
    end else if (msTick && !blockedLong) begin
      nxt_cur.blkMs = cur_ff.blkMs + 15'h1;
    end

    unique case (cur_ff.st)
      spf_pkg::ST_IDLE: begin
        nxt_cur.holdMs = 15'h0;
        if (bothHeld) begin
          nxt_cur.st = spf_pkg::ST_VIEW;
        end else if (cur_ff.setupEn) begin
          nxt_cur.paramKeyEvt = keyRise;
        end
      end
      spf_pkg::ST_VIEW: begin
        if (!anyHeld) begin
          nxt_cur.st = spf_pkg::ST_IDLE;
        end else if (!bothHeld) begin
          nxt_cur.holdMs = 15'h0;
        end else if (cur_ff.holdMs == spf_pkg::EDIT_HOLD_MS) begin
          nxt_cur.st = spf_pkg::ST_EDIT;
          nxt_cur.idleMs = 15'h0;
        end else if (msTick) begin
          nxt_cur.holdMs = cur_ff.holdMs + 15'h1;
        end
      end
      spf_pkg::ST_EDIT: begin
        // Device part stays within 1..F, group within 0..7
        if (keyRise[spf_pkg::KEY_INC] && !keyDec && addr != 7'h7f) begin
          if (cur_ff.device == spf_pkg::DEVICE_MAX) begin
            nxt_cur.device = spf_pkg::DEVICE_MIN;
            nxt_cur.group = cur_ff.group + 3'h1;
          end else begin
            nxt_cur.device = cur_ff.device + 4'h1;
          end
        end else if (keyRise[spf_pkg::KEY_DEC] && !keyInc && addr != 7'h01) begin
          if (cur_ff.device == spf_pkg::DEVICE_MIN) begin
            nxt_cur.device = spf_pkg::DEVICE_MAX;
            nxt_cur.group = cur_ff.group - 3'h1;
          end else begin
            nxt_cur.device = cur_ff.device - 4'h1;
          end
        end
        if (anyHeld) begin
          nxt_cur.idleMs = 15'h0;
        end else if (cur_ff.idleMs == spf_pkg::SAVE_IDLE_MS) begin
          nxt_cur.st = spf_pkg::ST_IDLE;
          nxt_cur.nvSave = 1'b1;
          nxt_cur.saved = 1'b1;
          irqSet[spf_pkg::IRQ_SAVED] = 1'b1;
        end else if (msTick) begin
          nxt_cur.idleMs = cur_ff.idleMs + 15'h1;
        end
      end
      // A corrupted state code falls back to idle rather than locking up
      default: begin
        nxt_cur.st = spf_pkg::ST_IDLE;
      end
    endcase

    // Reset follows the save by one cycle so storage sees the address first
    if (cur_ff.saved) begin
      nxt_cur.saved = 1'b0;
      nxt_cur.swReset = 1'b1;
    end

    // Display
    nxt_cur.dispDots = 3'h0;
    nxt_cur.dispNumOn = 1'b1;
    unique case (cur_ff.st)
      spf_pkg::ST_VIEW: begin
        if (bothHeld) begin
          nxt_cur.dispNumber = {1'b0, addr};
        end else if (keyDec) begin
          nxt_cur.dispNumber = {5'h0, cur_ff.group};
        end else begin
          nxt_cur.dispNumber = {4'h0, cur_ff.device};
        end
      end
      spf_pkg::ST_EDIT: begin
        nxt_cur.dispNumber = {1'b0, addr};
        nxt_cur.dispNumOn = cur_ff.flashOn;
      end
      spf_pkg::ST_IDLE: begin
        if (shownCode != 5'h0) begin
          nxt_cur.dispNumber = {3'h0, shownCode};
          nxt_cur.dispNumOn = cur_ff.flashOn;
        end else begin
          nxt_cur.dispNumber = 8'h0;
          nxt_cur.dispNumOn = 1'b0;
          nxt_cur.dispDots = 3'h7;
        end
      end
      default: nxt_cur.dispNumber = 8'h0;
    endcase

    nxt_cur.faultSwitch = ~|signalFaults;
    nxt_cur.holdPos = guiderLock;
    nxt_cur.anyPrev = anyFault;
    nxt_cur.lockPrev = guiderLock;
    irqSet[spf_pkg::IRQ_FAULT] = anyFault && !cur_ff.anyPrev;
    irqSet[spf_pkg::IRQ_LOCK] = guiderLock != cur_ff.lockPrev;
    irqSet[spf_pkg::IRQ_KEY] = |nxt_cur.paramKeyEvt;

    // APB: zero wait states, read data captured in the setup cycle
    if (setupAcc) begin
      nxt_cur.pslverr = 1'b0;
      nxt_cur.prdata = 32'h0;
      unique case (regSel)
        SEL_CTRL: nxt_cur.prdata = {31'h0, cur_ff.setupEn};
        SEL_STATUS: nxt_cur.prdata = {28'h0, cur_ff.irqStat};
        SEL_MASK: nxt_cur.prdata = {28'h0, cur_ff.irqMask};
        SEL_ADDR: nxt_cur.prdata = {25'h0, addr};
        SEL_FAULT: nxt_cur.prdata = {11'h0, shownCode, faultIn};
        SEL_PANEL: begin
          nxt_cur.prdata = {25'h0, cur_ff.faultSwitch, cur_ff.holdPos,
            cur_ff.st, keys};
        end
        default: nxt_cur.pslverr = 1'b1;
      endcase
    end
    if (wrAcc) begin
      unique case (regSel)
        SEL_CTRL: nxt_cur.setupEn = pwdata[0];
        SEL_STATUS: irqClr = pwdata[3:0];
        SEL_MASK: nxt_cur.irqMask = pwdata[3:0];
        default: ;
      endcase
    end

    // A new event wins over a clear in the same cycle
    nxt_cur.irqStat = (cur_ff.irqStat & ~irqClr) | irqSet;
    nxt_cur.irq = |(nxt_cur.irqStat & nxt_cur.irqMask);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= RST_STATE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign irq = cur_ff.irq;
  assign dispNumber = cur_ff.dispNumber;
  assign dispNumOn = cur_ff.dispNumOn;
  assign dispDots = cur_ff.dispDots;
  assign faultSwitch = cur_ff.faultSwitch;
  assign holdPosition = cur_ff.holdPos;
  assign addrGroup = cur_ff.group;
  assign addrDevice = cur_ff.device;
  assign nvSave = cur_ff.nvSave;
  assign swReset = cur_ff.swReset;
  assign paramKeyEvt = cur_ff.paramKeyEvt;

endmodule

// ==== test/spf_operator_model.sv ====
// Operator keys and fault sensing circuit in front of the panel
module spf_operator_model (
  input wire logic sys_clk,
  input wire logic [2:0] keyCmd,
  input wire logic [15:0] faultCmd,
  output logic keySetup,
  output logic keyDec,
  output logic keyInc,
  output logic [15:0] faultIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts change only after an edge, as a debounced panel would
  always @(posedge sys_clk) begin
    {keyInc, keyDec, keySetup} <= keyCmd;
    faultIn <= faultCmd & 16'hfbff;
  end
endmodule

// ==== test/spf_panel_assertions.sv ====
// Checker of the panel display, fault switch and address save
module spf_panel_assertions #(
  parameter int unsigned MS_CYCLES = 250000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic keyDec,
  input wire logic keyInc,
  input wire logic [15:0] faultIn,
  input wire logic guiderLock,
  input wire logic [7:0] dispNumber,
  input wire logic dispNumOn,
  input wire logic [2:0] dispDots,
  input wire logic faultSwitch,
  input wire logic holdPosition,
  input wire logic [2:0] addrGroup,
  input wire logic nvSave,
  input wire logic swReset
);
  logic up, busy, busyD, quiet;
  logic [15:0] prevF;
  int unsigned blkCnt;
  function automatic logic [7:0] lowCode(input logic [15:0] f);
    lowCode = 8'h00;
    for (int k = 15; k >= 0; k--)
      if (f[k])
        lowCode = 8'(k + 1);
  endfunction
  // Panel used since the last save: the display may show an address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 1'b0;
      busy <= 1'b0;
      busyD <= 1'b0;
      prevF <= 16'h0;
      blkCnt <= 0;
    end else begin
      up <= 1'b1;
      busy <= (busy | keyDec | keyInc) & ~swReset;
      busyD <= busy;
      prevF <= faultIn;
      blkCnt <= (faultIn == 16'h1000) ? blkCnt + 1 : 0;
    end
  end
  assign quiet = up && !busy && !busyD;
  sequence bothHeld;
    keyDec && keyInc;
  endsequence
  sequence decOnly;
    keyDec && !keyInc;
  endsequence
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_dots_idle: assert property (quiet && prevF == 0 |->
    dispDots == 3'h7 && !dispNumOn) else $error("dots not steady");
  a_code_shown: assert property (quiet && prevF != 0 |->
    dispNumber == lowCode(prevF) && dispDots == 0) else $error("bad code");
  a_switch_open: assert property (up && (prevF & 16'h8a0b) != 0 |->
    !faultSwitch) else $error("switch not opened");
  a_switch_kept: assert property (up && (prevF & 16'h9a0b) == 0 &&
    !$past(faultIn[12], 2) |-> faultSwitch) else $error("switch opened");
  a_block_late: assert property (blkCnt > 5010 * MS_CYCLES |->
    !faultSwitch) else $error("blocked motor not signalled");
  a_view_group: assert property (bothHeld ##1 decOnly [*4] |->
    dispNumber == {5'h0, addrGroup}) else $error("group not shown");
  a_save_reset: assert property (nvSave |=> swReset && !nvSave)
    else $error("no reset after save");
  a_hold_lock: assert property ($changed(guiderLock) |=>
    holdPosition == $past(guiderLock)) else $error("lock not followed");
endmodule
bind spf_panel spf_panel_assertions #(.MS_CYCLES(MS_CYCLES)) chk (.sys_clk,
  .rst_n, .keyDec, .keyInc, .faultIn, .guiderLock, .dispNumber, .dispNumOn,
  .dispDots, .faultSwitch, .holdPosition, .addrGroup, .nvSave, .swReset);

// ==== test/spf_panel_tb.sv ====
// Self-checking bench of the setup panel and fault indicator
module spf_panel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 2;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic guiderLock = 0, lastOn = 0, err;
  logic [2:0] lastEvt = 3'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] keyCmd = 3'h0, dispDots, addrGroup, paramKeyEvt;
  logic [15:0] faultCmd = 16'h0, faultIn;
  logic pready, pslverr, irq, keySetup, keyDec, keyInc, dispNumOn;
  logic faultSwitch, holdPosition, nvSave, swReset;
  logic [7:0] dispNumber;
  logic [3:0] addrDevice;
  int n_errors = 0, samples_checked = 0, cycles = 0, flips = 0;
  int seed = 8976, addr = 5, setupEvts = 0, tw;
  int sigCodes[$] = '{1, 2, 4, 10, 12, 16};
  spf_panel #(.MS_CYCLES(MSC)) dut (.sys_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .keySetup,
    .keyDec, .keyInc, .faultIn, .guiderLock, .dispNumber, .dispNumOn,
    .dispDots, .faultSwitch, .holdPosition, .addrGroup, .addrDevice,
    .nvSave, .swReset, .paramKeyEvt);
  spf_operator_model ops (.sys_clk, .keyCmd, .faultCmd, .keySetup, .keyDec,
    .keyInc, .faultIn);
  initial forever #2 sys_clk = ~sys_clk;
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Ceiling well above the 63k cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    setupEvts += paramKeyEvt[0];
    flips += (dispNumOn !== lastOn);
    lastOn = dispNumOn;
    if (paramKeyEvt != 3'h0)
      lastEvt = paramKeyEvt;
    if (cycles == 90000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic step(input logic [2:0] k, input int n);
    repeat (n) begin
      keyCmd <= k;
      tick(6);
      keyCmd <= 3'h0;
      tick(6);
      if (k[2])
        addr = (addr & 15) == 15 ? addr + 2 : addr + 1;
      else if (k[1])
        addr = addr > 1 ? addr - 1 : 1;
    end
  endtask
  function automatic int lowest(input logic [15:0] f);
    lowest = 0;
    for (int k = 15; k >= 0; k--)
      if (f[k])
        lowest = k + 1;
  endfunction
  function automatic logic expSw(input logic [15:0] f);
    expSw = 1'b1;
    foreach (sigCodes[i])
      if (f[sigCodes[i] - 1])
        expSw = 1'b0;
  endfunction
  initial begin
    tick(8);
    chk({pready, faultSwitch, addrGroup, addrDevice}, 9'h085);
    rst_n <= 1'b1;
    tick(2);
    for (int c = 1; c <= 16; c++) begin
      faultCmd <= 16'h1 << (c - 1);
      tick(4);
      chk(lowest(faultIn) ? dispNumber : dispDots, c == 11 ? 7 : c);
      chk(faultSwitch, expSw(faultIn));
    end
    repeat (20) begin
      faultCmd <= 16'($random(seed)) & 16'hebff | 16'h0080;
      tick(4);
      chk(dispNumber, lowest(faultIn));
      chk(faultSwitch, expSw(faultIn));
    end
    faultCmd <= 16'h0004;
    tick(4);
    flips = 0;
    tick(1000 * MSC + 20);
    chk(flips >= 2, 1);
    faultCmd <= 16'h1000;
    tick(5000 * MSC - 8);
    chk(faultSwitch, 1);
    tick(40);
    chk(faultSwitch, 0);
    faultCmd <= 16'h0;
    tick(4);
    chk({dispDots, dispNumOn, faultSwitch}, 5'h1d);
    $display("fault display done");
    apb(0, 8'h18, 0);
    chk({err, rd}, 33'h100000000);
    apb(1, spf_pkg::REG_STATUS, 15);
    apb(1, spf_pkg::REG_MASK, 4);
    step(3'h1, 1);
    chk(setupEvts, 0);
    apb(1, spf_pkg::REG_CTRL, 1);
    step(3'h1, 1);
    chk({setupEvts, irq}, 3);
    for (int k = 1; k < 3; k++) begin
      keyCmd <= 3'h1 << k;
      tick(6);
      keyCmd <= 3'h0;
      tick(6);
      chk(lastEvt, 3'h1 << k);
    end
    apb(1, spf_pkg::REG_MASK, 0);
    tick(2);
    chk(irq, 0);
    apb(1, spf_pkg::REG_STATUS, 4);
    apb(1, spf_pkg::REG_MASK, 4);
    tick(2);
    chk(irq, 0);
    guiderLock <= 1'b1;
    tick(3);
    chk(holdPosition, 1);
    $display("registers done");
    keyCmd <= 3'h6;
    tick(6);
    chk(dispNumber, addr);
    keyCmd <= 3'h2;
    tick(6);
    chk(dispNumber, addr >> 4);
    keyCmd <= 3'h6;
    tick(6);
    keyCmd <= 3'h4;
    tick(6);
    chk(dispNumber, addr & 15);
    keyCmd <= 3'h6;
    tick(3990 * MSC);
    apb(0, spf_pkg::REG_PANEL, 0);
    chk(rd[4:3], 1);
    tick(30 * MSC);
    apb(0, spf_pkg::REG_PANEL, 0);
    chk(rd[4:3], 2);
    keyCmd <= 3'h0;
    tick(4);
    flips = 0;
    tick(1000 * MSC + 20);
    chk(flips >= 2, 1);
    step(3'h4, 3);
    step(3'h2, 9);
    step(3'h4, 17);
    apb(0, spf_pkg::REG_ADDR, 0);
    chk({rd, dispNumber}, {addr, 8'(addr)});
    chk({addrGroup, addrDevice}, addr);
    tw = 0;
    while (nvSave !== 1'b1 && tw < 20100 * MSC) begin
      @(posedge sys_clk);
      tw++;
    end
    chk({nvSave, tw > 19900 * MSC}, 3);
    @(posedge sys_clk);
    chk(swReset, 1);
    apb(0, spf_pkg::REG_STATUS, 0);
    chk(rd[1], 1);
    $display("address edit done");
    final_report();
  end
endmodule
